// *** dtc_top.sv ***
// Dual timer/counter with mode, control, count and enable registers
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module dtc_top
(
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   input wire dtc_pkg::dtc_bus_req_t bus_req_in,
   output logic [7:0] bus_rdata_out,
   input wire logic [1:0] count_pin_in,
   input wire logic ext_gate_pin_0_in,
   input wire logic ext_gate_pin_1_in,
   input wire logic [1:0] irq_vector_ack_in,
   output logic [1:0] timer_irq_out,
   output logic baud_tick_out
);
   import dtc_pkg::*;

   // ****************************************************************
   // State
   // ****************************************************************
   logic [7:0] timer_mode_reg_q;
   logic [7:0] timer_control_reg_q;
   logic [7:0] irq_en_q;
   logic [7:0] lo_q [2];
   logic [7:0] hi_q [2];
   logic [2:0] phase_q;
   logic [1:0] pin_smp_q;
   logic [7:0] rdata_q;
   logic [1:0] irq_q;
   logic baud_q;

   logic per_tick;
   logic [1:0] gate_pin;
   logic [1:0] ovf;
   logic hi3_ovf;
   logic [1:0] ovf_clr;
   logic t0_mode3;
   dtc_cfg_t cfg [2];
   logic [1:0] run;
   logic [1:0] inc;

   assign gate_pin = {ext_gate_pin_1_in, ext_gate_pin_0_in};
   assign cfg[0] = dtc_cfg_t'(timer_mode_reg_q[MODE_T0_BASE +: 4]);
   assign cfg[1] = dtc_cfg_t'(timer_mode_reg_q[MODE_T1_BASE +: 4]);
   assign run[0] = timer_control_reg_q[CTRL_RUN0];
   assign run[1] = timer_control_reg_q[CTRL_RUN1];
   assign t0_mode3 = (cfg[0].mode == 2'(DTC_MODE3));

   // ****************************************************************
   // Peripheral cycle phase
   // ****************************************************************
   // six-clock peripheral cycle
   always_ff @(posedge ref_clk_in)
   begin
      if (sys_rst_in)
         phase_q <= 3'h0;
      else if (phase_q == PHASE_LAST)
         phase_q <= 3'h0;
      else
         phase_q <= phase_q + 3'h1;
   end
   assign per_tick = (phase_q == PHASE_LAST);

   always_ff @(posedge ref_clk_in)
   begin
      if (sys_rst_in)
         pin_smp_q <= 2'h0;
      else if (per_tick)
         pin_smp_q <= count_pin_in;
   end

   // ****************************************************************
   // Per-timer count enable and counting
   // ****************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_tmr
         logic src_evt;
         logic run_eff;
         assign src_evt = per_tick &
            (cfg[gi].src ? (pin_smp_q[gi] & ~count_pin_in[gi]) : 1'b1);
         // Timer 1 run bit belongs to timer 0 high byte in split mode
         assign run_eff = (gi == 1 && t0_mode3) ? 1'b1 : run[gi];
         assign inc[gi] = src_evt & run_eff & (~cfg[gi].gate | gate_pin[gi]);
      end
   endgenerate

   // Overflow detection per mode
   always_comb
   begin
      for (int i = 0; i < 2; i++)
      begin
         unique case (cfg[i].mode)
            2'(DTC_MODE13): ovf[i] = inc[i] & (lo_q[i][4:0] == PRESCALE_MAX) & (&hi_q[i]);
            2'(DTC_MODE16): ovf[i] = inc[i] & (&lo_q[i]) & (&hi_q[i]);
            2'(DTC_MODE8R): ovf[i] = inc[i] & (&lo_q[i]);
            // timer 1 holds in mode 3
            2'(DTC_MODE3): ovf[i] = (i == 0) ? (inc[i] & (&lo_q[i])) : 1'b0;
         endcase
      end
   end

   // high byte counts cycles on run bit 1
   assign hi3_ovf = t0_mode3 & per_tick & run[1] & (&hi_q[0]);

   assign ovf_clr = irq_vector_ack_in;

   // Count byte update with software writes taking priority
   always_ff @(posedge ref_clk_in)
   begin
      if (sys_rst_in)
      begin
         lo_q[0] <= RST_BYTE;
         lo_q[1] <= RST_BYTE;
         hi_q[0] <= RST_BYTE;
         hi_q[1] <= RST_BYTE;
      end
      else
      begin
         for (int i = 0; i < 2; i++)
         begin
            if (inc[i])
            begin
               unique case (cfg[i].mode)
                  2'(DTC_MODE13):
                  begin
                     lo_q[i][4:0] <= lo_q[i][4:0] + 5'h01;
                     if (lo_q[i][4:0] == PRESCALE_MAX)
                        hi_q[i] <= hi_q[i] + 8'h01;
                  end
                  2'(DTC_MODE16):
                  begin
                     lo_q[i] <= lo_q[i] + 8'h01;
                     if (&lo_q[i])
                        hi_q[i] <= hi_q[i] + 8'h01;
                  end
                  // timer 1 reload keeps high byte
                  2'(DTC_MODE8R):
                     lo_q[i] <= (&lo_q[i]) ? hi_q[i] : lo_q[i] + 8'h01;
                  2'(DTC_MODE3):
                     if (i == 0)
                        lo_q[i] <= lo_q[i] + 8'h01;
               endcase
            end
            if (i == 0 && t0_mode3 && per_tick && run[1])
               hi_q[0] <= hi_q[0] + 8'h01;
         end
         if (bus_req_in.wr)
         begin
            unique case (bus_req_in.addr)
               ADDR_CNT0_LO: lo_q[0] <= bus_req_in.wdata;
               ADDR_CNT0_HI: hi_q[0] <= bus_req_in.wdata;
               ADDR_CNT1_LO: lo_q[1] <= bus_req_in.wdata;
               ADDR_CNT1_HI: hi_q[1] <= bus_req_in.wdata;
               default: ;
            endcase
         end
      end
   end

   // ****************************************************************
   // Mode, enable and control registers
   // ****************************************************************
   // Mode register write
   always_ff @(posedge ref_clk_in)
   begin
      if (sys_rst_in)
         timer_mode_reg_q <= RST_BYTE;
      else if (bus_req_in.wr && bus_req_in.addr == ADDR_MODE)
         timer_mode_reg_q <= bus_req_in.wdata;
   end

   // Interrupt enable register write
   always_ff @(posedge ref_clk_in)
   begin
      if (sys_rst_in)
         irq_en_q <= RST_BYTE;
      else if (bus_req_in.wr && bus_req_in.addr == ADDR_IRQ_EN)
         irq_en_q <= {5'h00, bus_req_in.wdata[2:0]};
   end

   // Control register: software write, then clears, then sets win
   always_ff @(posedge ref_clk_in)
   begin
      if (sys_rst_in)
         timer_control_reg_q <= RST_BYTE;
      else
      begin
         // Later assignments override earlier ones
         if (bus_req_in.wr && bus_req_in.addr == ADDR_CTRL)
            timer_control_reg_q <= bus_req_in.wdata;
         if (ovf_clr[0])
            timer_control_reg_q[CTRL_OVF0] <= 1'b0;
         if (ovf_clr[1])
            timer_control_reg_q[CTRL_OVF1] <= 1'b0;
         // set on wrap, set beats clear
         if (ovf[0])
            timer_control_reg_q[CTRL_OVF0] <= 1'b1;
         // split high byte sets flag 1
         if (ovf[1] || hi3_ovf)
            timer_control_reg_q[CTRL_OVF1] <= 1'b1;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   // timer and global enable gating
   always_ff @(posedge ref_clk_in)
   begin
      if (sys_rst_in)
         irq_q <= 2'h0;
      else
      begin
         irq_q[0] <= timer_control_reg_q[CTRL_OVF0] & irq_en_q[IRQ_EN_T0] &
            irq_en_q[IRQ_EN_GLOBAL];
         irq_q[1] <= timer_control_reg_q[CTRL_OVF1] & irq_en_q[IRQ_EN_T1] &
            irq_en_q[IRQ_EN_GLOBAL];
      end
   end

   // timer 1 overflow as baud tick
   always_ff @(posedge ref_clk_in)
   begin
      if (sys_rst_in)
         baud_q <= 1'b0;
      else
         baud_q <= ovf[1];
   end

   // Read data, one cycle after read strobe
   always_ff @(posedge ref_clk_in)
   begin
      if (sys_rst_in)
         rdata_q <= RST_BYTE;
      else if (bus_req_in.rd)
      begin
         unique case (bus_req_in.addr)
            ADDR_MODE: rdata_q <= timer_mode_reg_q;
            ADDR_CTRL: rdata_q <= timer_control_reg_q;
            ADDR_CNT0_LO: rdata_q <= lo_q[0];
            ADDR_CNT0_HI: rdata_q <= hi_q[0];
            ADDR_CNT1_LO: rdata_q <= lo_q[1];
            ADDR_CNT1_HI: rdata_q <= hi_q[1];
            ADDR_IRQ_EN: rdata_q <= irq_en_q;
            default: rdata_q <= RST_BYTE;
         endcase
      end
      else
         rdata_q <= RST_BYTE;
   end

   assign bus_rdata_out = rdata_q;
   assign timer_irq_out = irq_q;
   assign baud_tick_out = baud_q;

endmodule
`default_nettype wire

// *** dtc_pkg.sv ***
// Package: register map, field layout, reset values and timing for the dual timer/counter
//
// Functional notes
// - Count input passes only when run set and gating clear or gate pin high; timer 1 ignores its run bit while timer 0 is in mode 3.
// - Wrap from all ones to zero sets the overflow flag, requesting interrupt.
// - Mode 0 is 13-bit: 5-bit divide-by-32 prescaler carries into high byte.
// - Mode 0 upper three low-byte bits are ignored by counting logic.
// - Setting run bit keeps count registers; counting resumes from held value.
// - Gating bits sit at mode register bit 7 (timer 1) and bit 3 (timer 0).
// - Mode 1 cascades low and high bytes into one 16-bit counter.
// - Mode 2 counts low byte, reloads from high byte on overflow, sets flag.
// - Mode 2 high byte writable any time; new value used at next reload.
// - Overflow flag clears in hardware when processor vectors to the timer routine.
// - Mode 3 timer 0 low byte is an 8-bit counter with timer 0 controls.
// - Mode 3 timer 0 high byte counts cycles, runs on run bit 1, sets flag 1.
// - Timer 1 in mode 3 halts and holds its count.
// - Timer 0 uses mode register bits 3..0 and control bits 0, 1, 4, 5.
// - Timer 1 uses mode register bits 7..4 and control bits 2, 3, 6, 7.
// - Timer 1 overflow is offered as baud clock for the serial port.
// - Timer 1 mode 2 reloads low from high, sets flag, keeps high byte.
// - Overflow interrupts only when timer enable and global enable both set.
// - Timer operation increments once per peripheral cycle of six clocks.
// - Counter pin sampled once per peripheral cycle; high then low increments.
// - Source select 0 picks internal cycles, 1 picks external pin falling edges.
package dtc_pkg;

   // ****************************************************************
   // Register addresses
   // ****************************************************************
   localparam logic [3:0] ADDR_MODE = 4'h0;
   localparam logic [3:0] ADDR_CTRL = 4'h1;
   localparam logic [3:0] ADDR_CNT0_LO = 4'h2;
   localparam logic [3:0] ADDR_CNT0_HI = 4'h3;
   localparam logic [3:0] ADDR_CNT1_LO = 4'h4;
   localparam logic [3:0] ADDR_CNT1_HI = 4'h5;
   localparam logic [3:0] ADDR_IRQ_EN = 4'h6;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int MODE_T1_BASE = 4;
   localparam int MODE_T0_BASE = 0;
   localparam int FLD_GATE = 3;
   localparam int FLD_SRC = 2;
   localparam int FLD_MODE_HI = 1;
   localparam int FLD_MODE_LO = 0;
   localparam int CTRL_OVF1 = 7;
   localparam int CTRL_RUN1 = 6;
   localparam int CTRL_OVF0 = 5;
   localparam int CTRL_RUN0 = 4;
   localparam int CTRL_EXT_FLAG1 = 3;
   localparam int CTRL_EXT_TYPE1 = 2;
   localparam int CTRL_EXT_FLAG0 = 1;
   localparam int CTRL_EXT_TYPE0 = 0;
   localparam int IRQ_EN_GLOBAL = 2;
   localparam int IRQ_EN_T1 = 1;
   localparam int IRQ_EN_T0 = 0;

   // ****************************************************************
   // Reset values and widths
   // ****************************************************************
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam int PRESCALE_BITS = 5;
   localparam logic [4:0] PRESCALE_MAX = 5'h1f;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 25;
   localparam int PER_CYCLE_NS = 150;
   localparam int PER_CYCLE_CLKS = (PER_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0] PHASE_LAST = 3'(PER_CYCLE_CLKS - 1);

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [1:0]
   {
      DTC_MODE13,
      DTC_MODE16,
      DTC_MODE8R,
      DTC_MODE3
   } dtc_mode_t;

   typedef struct packed
   {
      logic gate;
      logic src;
      logic [1:0] mode;
   } dtc_cfg_t;

   typedef struct packed
   {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } dtc_bus_req_t;

endpackage

// *** dtc_props.sv ***
// Checker: port-level properties of the dual timer/counter
`timescale 1ns/1ps
`default_nettype none
module dtc_props
(
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   input wire dtc_pkg::dtc_bus_req_t bus_req_in,
   input wire logic [7:0] bus_rdata_out,
   input wire logic [1:0] count_pin_in,
   input wire logic ext_gate_pin_0_in,
   input wire logic ext_gate_pin_1_in,
   input wire logic [1:0] irq_vector_ack_in,
   input wire logic [1:0] timer_irq_out,
   input wire logic baud_tick_out
);
   import dtc_pkg::*;
   logic [7:0] mode_q;
   logic [7:0] ctl_q;
   logic [2:0] en_q;
   logic [1:0] en_ok;
   logic [5:0] ctl_k;
   logic t1_halt;
   logic t1_idle;
   logic clr0;
   // ****
   // Shadow of software settings
   // ****
   always_ff @(posedge ref_clk_in)
   begin
      if (sys_rst_in)
      begin
         mode_q <= 8'h00;
         ctl_q <= 8'h00;
         en_q <= 3'h0;
      end
      else if (bus_req_in.wr)
      begin
         if (bus_req_in.addr == ADDR_MODE)
            mode_q <= bus_req_in.wdata;
         if (bus_req_in.addr == ADDR_CTRL)
            ctl_q <= bus_req_in.wdata;
         if (bus_req_in.addr == ADDR_IRQ_EN)
            en_q <= bus_req_in.wdata[2:0];
      end
   end
   // Derived conditions
   assign en_ok = en_q[1:0] & {2{en_q[2]}};
   assign ctl_k = {ctl_q[6], ctl_q[4], ctl_q[3:0]};
   assign t1_halt = mode_q[5:4] == 2'b11;
   assign t1_idle = !ctl_q[6] && mode_q[1:0] != 2'b11;
   assign clr0 = irq_vector_ack_in[0] || bus_req_in.wr;
   // ****
   // Properties
   // ****
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (sys_rst_in);
   irq_enable_a: assert property (
      (timer_irq_out & ~$past(en_ok)) == 2'b00) else $error("request while disabled");
   ack_clear_a: assert property (
      irq_vector_ack_in[0] && !bus_req_in.wr && !ctl_q[4] |=> ##1 !timer_irq_out[0])
      else $error("request kept after vectoring");
   irq_hold_a: assert property (
      $fell(timer_irq_out[0]) |-> $past(clr0, 2)) else $error("request dropped alone");
   baud_space_a: assert property (
      baud_tick_out |=> !baud_tick_out [*5]) else $error("baud ticks too close");
   halt_hold_a: assert property (
      t1_halt && $past(t1_halt) && $past(t1_halt, 2) |-> !baud_tick_out)
      else $error("halted timer overflowed");
   run_off_a: assert property (
      t1_idle && $past(t1_idle) && $past(t1_idle, 2) |-> !baud_tick_out)
      else $error("stopped timer overflowed");
   mode_read_a: assert property (
      $past(bus_req_in.rd) && $past(bus_req_in.addr) == ADDR_MODE
      |-> bus_rdata_out == $past(mode_q)) else $error("mode readback wrong");
   ctrl_read_a: assert property (
      $past(bus_req_in.rd) && $past(bus_req_in.addr) == ADDR_CTRL
      |-> {bus_rdata_out[6], bus_rdata_out[4:0]} == $past(ctl_k))
      else $error("control readback wrong");
   cover property ($rose(timer_irq_out[0]));
   cover property (baud_tick_out);
   cover property (irq_vector_ack_in[1]);
endmodule
bind dtc_top dtc_props u_dtc_props (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
   .bus_req_in(bus_req_in), .bus_rdata_out(bus_rdata_out), .count_pin_in(count_pin_in),
   .ext_gate_pin_0_in(ext_gate_pin_0_in), .ext_gate_pin_1_in(ext_gate_pin_1_in),
   .irq_vector_ack_in(irq_vector_ack_in), .timer_irq_out(timer_irq_out),
   .baud_tick_out(baud_tick_out));
`default_nettype wire

// *** tb.sv ***
// Testbench: register-level scenarios for the dual timer/counter
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
   begin \
      checks_done++; \
      if ((got) !== (ex)) \
      begin \
         num_errors++; \
         $display("wrong value %s expected %h seen %h", nm, ex, got); \
      end \
   end
module tb;
   import dtc_pkg::*;
   logic ref_clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   dtc_bus_req_t req = '0;
   logic [7:0] rdata;
   logic [1:0] pin = 2'b00;
   logic gate_pin_0 = 1'b0;
   logic gate_pin_1 = 1'b0;
   logic [1:0] ack = 2'b00;
   logic [1:0] irq;
   logic baud;
   logic rd_q = 1'b0;
   logic [15:0] note;
   logic [15:0] s;
   logic [15:0] expq[$];
   logic [31:0] seed = 32'hbbeb_6a6d;
   int num_errors = 0;
   int checks_done = 0;
   int cyc_q = 0;
   int baud_n = 0;
   int n;
   always #12.5 ref_clk_in = ~ref_clk_in;
   dtc_top u_dtc_top (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .bus_req_in(req),
      .bus_rdata_out(rdata), .count_pin_in(pin), .ext_gate_pin_0_in(gate_pin_0),
      .ext_gate_pin_1_in(gate_pin_1), .irq_vector_ack_in(ack), .timer_irq_out(irq),
      .baud_tick_out(baud));
   // ****
   // Bus and pin tasks
   // ****
   function automatic logic [31:0] xs(input logic [31:0] v);
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction
   task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic w = 1'b1);
      req <= '{a, d, w, ~w};
      @(posedge ref_clk_in);
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
      expq.push_back({m, e & m});
      wr(a, 8'h00, 1'b0);
   endtask
   task automatic idle(input int c);
      req <= '0;
      repeat (c) @(posedge ref_clk_in);
   endtask
   // Waits for a timer request and bounds the delay
   task automatic wirq(input int t, input int lo, input int hi);
      req <= '0;
      n = 0;
      do
      begin
         @(negedge ref_clk_in);
         n++;
      end
      while (irq[t] !== 1'b1 && n < 3000);
      @(posedge ref_clk_in);
      `CHK("wait cycles", (n >= lo && n <= hi), 1'b1)
   endtask
   task automatic fall0(input int k);
      repeat (k)
      begin
         pin <= 2'b11;
         idle(8);
         pin <= 2'b00;
         idle(8);
      end
   endtask
   task automatic pulse_ack(input int t);
      ack[t] <= 1'b1;
      idle(1);
      ack <= 2'b00;
      idle(2);
      `CHK("request after ack", 1'b0, irq[t])
   endtask
   task automatic results();
      if (num_errors == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Read monitor, baud tick count and watchdog
   always @(posedge ref_clk_in)
   begin
      rd_q <= req.rd;
      cyc_q <= cyc_q + 1;
      // Unknown tick counts as a tick
      if (!sys_rst_in && baud !== 1'b0)
         baud_n++;
      if (rd_q)
      begin
         note = expq.pop_front();
         `CHK("read data", note[7:0], rdata & note[15:8])
      end
      if (cyc_q == 20000)
      begin
         num_errors++;
         results();
      end
   end
   // ****
   // Scenarios
   // ****
   initial
   begin
      repeat (16) @(posedge ref_clk_in);
      sys_rst_in <= 1'b0;
      for (int i = 0; i < 8; i++)
         rd(4'(i), 8'h00);
      wr(ADDR_IRQ_EN, 8'h07);
      // 16-bit wrap of timer 0
      wr(ADDR_MODE, 8'h01);
      wr(ADDR_CNT0_LO, 8'hff);
      wr(ADDR_CNT0_HI, 8'hff);
      wr(ADDR_CTRL, 8'h10);
      wirq(0, 1, 10);
      wr(ADDR_CTRL, 8'h20);
      rd(ADDR_CNT0_LO, 8'h00);
      rd(ADDR_CNT0_HI, 8'h00);
      rd(ADDR_CTRL, 8'h20);
      pulse_ack(0);
      // 13-bit timer 1, upper low-byte bits set
      wr(ADDR_MODE, 8'h00);
      wr(ADDR_CNT1_LO, 8'ha0);
      wr(ADDR_CNT1_HI, 8'hff);
      wr(ADDR_CTRL, 8'h40);
      wirq(1, 185, 198);
      wr(ADDR_CTRL, 8'h80);
      rd(ADDR_CNT1_HI, 8'h00);
      rd(ADDR_CNT1_LO, 8'h00, 8'h1f);
      pulse_ack(1);
      // Auto-reload timer 1, reload value changed while running
      wr(ADDR_MODE, 8'h20);
      wr(ADDR_CNT1_HI, 8'hf0);
      wr(ADDR_CNT1_LO, 8'hfe);
      wr(ADDR_CTRL, 8'h40);
      wr(ADDR_CNT1_HI, 8'hf8);
      wirq(1, 7, 14);
      wr(ADDR_CTRL, 8'h80);
      `CHK("baud ticks", 2, baud_n)
      rd(ADDR_CNT1_LO, 8'hf8);
      rd(ADDR_CNT1_HI, 8'hf8);
      pulse_ack(1);
      // Gated edge counting on timer 0, gated timer 1 held off
      seed = xs(seed);
      s = {8'h00, seed[7:0]} + 16'h0003;
      wr(ADDR_MODE, 8'hcd);
      wr(ADDR_CNT0_LO, seed[7:0]);
      wr(ADDR_CNT0_HI, 8'h00);
      wr(ADDR_CTRL, 8'h50);
      fall0(2);
      rd(ADDR_CNT0_LO, seed[7:0]);
      gate_pin_0 <= 1'b1;
      fall0(3);
      rd(ADDR_CNT0_LO, s[7:0]);
      rd(ADDR_CNT0_HI, s[15:8]);
      rd(ADDR_CNT1_LO, 8'hf8);
      // Split timer 0, timer 1 halted
      // stop timers before mode change
      wr(ADDR_CTRL, 8'h00);
      // timer 1 parked in mode 3
      wr(ADDR_MODE, 8'h33);
      wr(ADDR_CNT0_LO, 8'hff);
      wr(ADDR_CNT0_HI, 8'hff);
      wr(ADDR_CNT1_LO, 8'h55);
      wr(ADDR_CTRL, 8'h40);
      wirq(1, 1, 10);
      wr(ADDR_CTRL, 8'h80);
      rd(ADDR_CNT0_HI, 8'h00);
      rd(ADDR_CNT0_LO, 8'hff);
      rd(ADDR_CNT1_LO, 8'h55);
      rd(ADDR_MODE, 8'h33);
      // Global enable masks a pending request
      wr(ADDR_IRQ_EN, 8'h03);
      idle(2);
      `CHK("masked request", 1'b0, irq[1])
      wr(ADDR_IRQ_EN, 8'h07);
      idle(2);
      `CHK("unmasked request", 1'b1, irq[1])
      pulse_ack(1);
      idle(4);
      `CHK("baud ticks after split", 2, baud_n)
      results();
   end
endmodule
`default_nettype wire
